/* File: pkg/lgs_gate_if.sv */
// lgs_gate_if: carries one gate's enables and its selected sources
// assumes: all signals on REF_CLK; enables, src and invert driven by the top, terms and gate_out driven by lgs_gate
interface lgs_gate_if;
   logic [7:0] enables;
   logic [3:0] src;
   logic invert;
   logic [7:0] terms;
   logic gate_out;
   modport top (output enables, output src, output invert,
      input terms, input gate_out);
   modport gate (input enables, input src, input invert,
      output terms, output gate_out);
endinterface

/* File: pkg/lgs_pkg.sv */
// lgs_pkg: register map, field layout and sizes of the gate input select
// assumes: 32-bit classic wishbone, byte addresses, one register per word
package lgs_pkg;
   localparam int LGS_ADDR_W = 4;
   localparam int LGS_DATA_W = 32;
   localparam int LGS_REG_W = 16;
   localparam int LGS_NUM_SRC = 4;
   localparam int LGS_NUM_CAND = 8;
   localparam int LGS_SEL_W = 3;
   // register byte offsets
   localparam logic [LGS_ADDR_W-1:0] LGS_OFS_SEL_LOW = 4'h0;
   localparam logic [LGS_ADDR_W-1:0] LGS_OFS_SEL_HIGH = 4'h4;
   localparam logic [LGS_ADDR_W-1:0] LGS_OFS_POL = 4'h8;
   localparam logic [LGS_ADDR_W-1:0] LGS_OFS_SRC_SEL = 4'hc;
   localparam logic [LGS_ADDR_W-1:0] LGS_OFS_STATUS = 4'h0 + 4'h0 + 4'h0;
   // reset values
   localparam logic [LGS_REG_W-1:0] LGS_RST_SEL = 16'h0000;
   localparam logic [3:0] LGS_RST_POL = 4'h0;
   localparam logic [LGS_REG_W-1:0] LGS_RST_SRC = 16'h0000;
   // per gate byte: bit 2k+1 true enable of source k+1, bit 2k inverted
   localparam int LGS_GATE_LO_POS = 0;
   localparam int LGS_GATE_HI_POS = 8;
   localparam int LGS_FIELD_STRIDE = 4;
   // implemented bits of the source select register (bits 3,7,11,15 zero)
   localparam logic [LGS_REG_W-1:0] LGS_SRC_MASK = 16'h7777;
   localparam logic [LGS_REG_W-1:0] LGS_POL_MASK = 16'h000f;
   // state of the bus slave
   typedef enum logic [0:0] {
      LGS_IDLE = 1'b0,
      LGS_ACK = 1'b1
   } lgs_bus_e;
endpackage

/* File: rtl/lgs_gate.sv */
// lgs_gate: enable gating of four sources into one gate channel
// assumes: enables and sources registered by the instantiating module
module lgs_gate (
   // gate channel signals
   lgs_gate_if.gate g
);
   import lgs_pkg::*;
   logic [7:0] next_terms;
   // true source on odd bit, inverted source on even bit; zero blocks
   always_comb begin
      for (int k = 0; k < LGS_NUM_SRC; k++) begin
         next_terms[2*k+1] = g.enables[2*k+1] & g.src[k];
         next_terms[2*k] = g.enables[2*k] & ~g.src[k];
      end
   end
   assign g.terms = next_terms;
   // how enabled terms combine is a cell-mode matter; or them here
   assign g.gate_out = (|next_terms) ^ g.invert;
endmodule // lgs_gate

/* File: rtl/lgs_top.sv */
// lgs_top: gate logic input select stage of a configurable logic cell
// assumes: classic wishbone master on REF_CLK, candidate inputs async
//
// Contract
// - bits 1,3,5,7 of select-low pass sources 1-4 true to gate 1.
// - bits 0,2,4,6 of select-low pass sources 1-4 inverted to gate 1.
// - bit 8 of select-low passes source 1 inverted to gate 2.
// - bits 1,3,5,7 of select-high pass sources 1-4 true to gate 3.
// - bits 0,2,4,6 of select-high pass sources 1-4 inverted to gate 3.
// - bits 9,11,13,15 of select-high pass sources 1-4 true to gate 4.
// - bits 8,10,12,14 of select-high pass sources 1-4 inverted to gate 4.
// - a zero enable bit withholds that form of the source.
// - select-low bits 9-15 odd give gate 2 true, even give inverted.
// - a set polarity bit inverts that gate's output.
// - each source picks one of eight candidates by a 3-bit field.
module lgs_top #(
   parameter int NUM_GATES = 4
) (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST_N,
   // wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [lgs_pkg::LGS_ADDR_W-1:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [lgs_pkg::LGS_DATA_W-1:0] WB_DAT_I,
   output logic [lgs_pkg::LGS_DATA_W-1:0] WB_DAT_O,
   output logic WB_ACK_O,
   // candidate signals, eight per data source, async
   input wire logic [lgs_pkg::LGS_NUM_CAND-1:0] SRC1_CAND,
   input wire logic [lgs_pkg::LGS_NUM_CAND-1:0] SRC2_CAND,
   input wire logic [lgs_pkg::LGS_NUM_CAND-1:0] SRC3_CAND,
   input wire logic [lgs_pkg::LGS_NUM_CAND-1:0] SRC4_CAND,
   // gate channel results
   output logic [7:0] GATE1_TERMS,
   output logic [7:0] GATE2_TERMS,
   output logic [7:0] GATE3_TERMS,
   output logic [7:0] GATE4_TERMS,
   output logic [3:0] GATE_OUT
);
   import lgs_pkg::*;

   logic [LGS_REG_W-1:0] sel_low, next_sel_low;
   logic [LGS_REG_W-1:0] sel_high, next_sel_high;
   logic [3:0] pol, next_pol;
   logic [LGS_REG_W-1:0] src_sel, next_src_sel;
   lgs_bus_e bus_st, next_bus_st;
   logic [LGS_DATA_W-1:0] next_dat;
   logic next_ack;
   logic [4*LGS_NUM_CAND-1:0] cand_meta, cand_sync;
   logic [3:0] src_now;
   logic [7:0] g_terms [4];
   logic [3:0] g_out;
   logic wr_go;

   // two-flop synchroniser; only cand_sync is read downstream
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         cand_meta <= '0;
         cand_sync <= '0;
      end else begin
         cand_meta <= {SRC4_CAND, SRC3_CAND, SRC2_CAND, SRC1_CAND};
         cand_sync <= cand_meta;
      end
   end

   // each data source picks one candidate by its own field
   always_comb begin
      for (int k = 0; k < LGS_NUM_SRC; k++) begin
         src_now[k] = cand_sync[k*LGS_NUM_CAND +
            src_sel[k*LGS_FIELD_STRIDE +: LGS_SEL_W]];
      end
   end

   // bus slave: ack one cycle after the request, then drop for a cycle
   assign wr_go = WB_CYC_I && WB_STB_I && WB_WE_I && bus_st == LGS_IDLE;
   always_comb begin
      next_bus_st = LGS_IDLE;
      next_ack = 1'b0;
      next_dat = '0;
      next_sel_low = sel_low;
      next_sel_high = sel_high;
      next_pol = pol;
      next_src_sel = src_sel;
      case (bus_st)
         LGS_IDLE: begin
            if (WB_CYC_I && WB_STB_I) begin
               next_bus_st = LGS_ACK;
               next_ack = 1'b1;
               case (WB_ADR_I)
                  LGS_OFS_SEL_LOW: next_dat = {16'h0000, sel_low};
                  LGS_OFS_SEL_HIGH: next_dat = {16'h0000, sel_high};
                  LGS_OFS_POL: next_dat = {28'h0000000, pol};
                  LGS_OFS_SRC_SEL: next_dat = {16'h0000, src_sel};
                  default: next_dat = '0; // unmapped reads zero
               endcase
            end
         end
         LGS_ACK: next_bus_st = LGS_IDLE;
         default: next_bus_st = LGS_IDLE;
      endcase
      // writes land with the ack edge, so the gates see them at once
      if (wr_go) begin
         for (int b = 0; b < 2; b++) begin
            if (WB_SEL_I[b]) begin
               case (WB_ADR_I)
                  LGS_OFS_SEL_LOW: next_sel_low[8*b +: 8] =
                     WB_DAT_I[8*b +: 8];
                  LGS_OFS_SEL_HIGH: next_sel_high[8*b +: 8] =
                     WB_DAT_I[8*b +: 8];
                  LGS_OFS_SRC_SEL: next_src_sel[8*b +: 8] =
                     WB_DAT_I[8*b +: 8] & LGS_SRC_MASK[8*b +: 8];
                  default: ;
               endcase
            end
         end
         if (WB_SEL_I[0] && WB_ADR_I == LGS_OFS_POL) begin
            next_pol = WB_DAT_I[3:0] & LGS_POL_MASK[3:0];
         end
      end
   end

   // register state
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         bus_st <= LGS_IDLE;
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= '0;
         sel_low <= LGS_RST_SEL;
         sel_high <= LGS_RST_SEL;
         pol <= LGS_RST_POL;
         src_sel <= LGS_RST_SRC;
      end else begin
         bus_st <= next_bus_st;
         WB_ACK_O <= next_ack;
         WB_DAT_O <= next_dat;
         sel_low <= next_sel_low;
         sel_high <= next_sel_high;
         pol <= next_pol;
         src_sel <= next_src_sel;
      end
   end

   // four gate channels, one byte of enables each
   lgs_gate_if gif [4] ();
   assign gif[0].enables = sel_low[LGS_GATE_LO_POS +: 8];
   assign gif[1].enables = sel_low[LGS_GATE_HI_POS +: 8];
   assign gif[2].enables = sel_high[LGS_GATE_LO_POS +: 8];
   assign gif[3].enables = sel_high[LGS_GATE_HI_POS +: 8];
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_gate
         assign gif[gi].src = src_now;
         assign gif[gi].invert = pol[gi];
         assign g_terms[gi] = gif[gi].terms;
         assign g_out[gi] = gif[gi].gate_out;
         lgs_gate u_gate (.g(gif[gi]));
      end
   endgenerate

   // outputs registered, one cycle after the enables change
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         GATE1_TERMS <= '0;
         GATE2_TERMS <= '0;
         GATE3_TERMS <= '0;
         GATE4_TERMS <= '0;
         GATE_OUT <= '0;
      end else begin
         GATE1_TERMS <= g_terms[0];
         GATE2_TERMS <= g_terms[1];
         GATE3_TERMS <= g_terms[2];
         GATE4_TERMS <= g_terms[3];
         GATE_OUT <= g_out;
      end
   end

   // assertions
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   sequence wr_low_s;
      wr_go && WB_SEL_I[1:0] == 2'b11 && WB_ADR_I == LGS_OFS_SEL_LOW;
   endsequence

   g1_true_a: assert property (GATE1_TERMS[1] ==
      $past(sel_low[1] & src_now[0]))
      else $error("gate 1 source 1 true term wrong");
   g1_inv_a: assert property (GATE1_TERMS[6] ==
      $past(sel_low[6] & ~src_now[3]))
      else $error("gate 1 source 4 inverted term wrong");
   g2_inv_a: assert property (GATE2_TERMS[0] ==
      $past(sel_low[8] & ~src_now[0]))
      else $error("gate 2 source 1 inverted term wrong");
   g3_true_a: assert property (GATE3_TERMS[5] ==
      $past(sel_high[5] & src_now[2]))
      else $error("gate 3 source 3 true term wrong");
   g3_inv_a: assert property (GATE3_TERMS[4] ==
      $past(sel_high[4] & ~src_now[2]))
      else $error("gate 3 source 3 inverted term wrong");
   g4_true_a: assert property (GATE4_TERMS[7] ==
      $past(sel_high[15] & src_now[3]))
      else $error("gate 4 source 4 true term wrong");
   g4_inv_a: assert property (GATE4_TERMS[0] ==
      $past(sel_high[8] & ~src_now[0]))
      else $error("gate 4 source 1 inverted term wrong");
   off_blocks_a: assert property ($past(sel_high == 16'h0000) |->
      GATE3_TERMS == 8'h00 && GATE4_TERMS == 8'h00)
      else $error("disabled term reached a gate");
   g2_true_a: assert property (GATE2_TERMS[7] ==
      $past(sel_low[15] & src_now[3]))
      else $error("gate 2 source 4 true term wrong");
   pol_out_a: assert property (GATE_OUT[1] ==
      $past((|sel_low[15:8] & ((sel_low[15:8] & {src_now[3], ~src_now[3],
      src_now[2], ~src_now[2], src_now[1], ~src_now[1], src_now[0],
      ~src_now[0]}) != 8'h00)) ^ pol[1]))
      else $error("gate 2 polarity wrong");
   src_pick_a: assert property (src_now[1] ==
      cand_sync[LGS_NUM_CAND + src_sel[LGS_FIELD_STRIDE +: LGS_SEL_W]])
      else $error("source 2 candidate wrong");
   wr_now_a: assert property (wr_low_s |=> sel_low ==
      $past(WB_DAT_I[15:0]) && WB_ACK_O)
      else $error("enable write not taken with ack");
endmodule // lgs_top

/* File: verification/lgs_src_model.sv */
// lgs_src_model: candidate signals of the four data source muxes
// assumes: bench sets wanted levels and the candidate the selects point at
module lgs_src_model (
   // clock
   input wire logic clk,
   // wanted source levels and selected candidate
   input wire logic [3:0] lvl,
   input wire logic [2:0] pick,
   // candidate buses
   output logic [7:0] cand1,
   output logic [7:0] cand2,
   output logic [7:0] cand3,
   output logic [7:0] cand4
);
   timeunit 1ns;
   timeprecision 1ns;
   // unpicked candidates carry the opposite level so a wrong pick shows
   always_ff @(posedge clk) begin
      cand1 <= {8{~lvl[0]}} ^ (8'h01 << pick);
      cand2 <= {8{~lvl[1]}} ^ (8'h01 << pick);
      cand3 <= {8{~lvl[2]}} ^ (8'h01 << pick);
      cand4 <= {8{~lvl[3]}} ^ (8'h01 << pick);
   end
endmodule // lgs_src_model

/* File: verification/lgs_top_bench.sv */
// lgs_top_bench: register and gate input checks of lgs_top
// assumes: classic wishbone, ack one cycle after the taking edge
module lgs_top_bench import lgs_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, cyc, stb, we, ack;
   logic [3:0] adr, lvl, pol;
   logic [2:0] pick;
   logic [31:0] dat_w, dat_r, rd, ex;
   logic [7:0] c1, c2, c3, c4, t1, t2, t3, t4;
   logic [3:0] gout;
   int errors = 0;
   int n_tests = 0;
   lgs_src_model src (.clk(clk), .lvl(lvl), .pick(pick), .cand1(c1),
      .cand2(c2), .cand3(c3), .cand4(c4));
   lgs_top uut (.REF_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h3),
      .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
      .SRC1_CAND(c1), .SRC2_CAND(c2), .SRC3_CAND(c3), .SRC4_CAND(c4),
      .GATE1_TERMS(t1), .GATE2_TERMS(t2), .GATE3_TERMS(t3),
      .GATE4_TERMS(t4), .GATE_OUT(gout));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic check(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one classic cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [3:0] a,
      input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      // no cycle count assumed: only the watchdog ends a lost answer
      while (ack !== 1'b1) @(posedge clk);
      rd = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   // term byte of one gate: odd bit true source, even bit inverted
   function automatic logic [7:0] tv(input logic [3:0] l);
      for (int k = 0; k < 4; k++) tv[2*k +: 2] = {l[k], ~l[k]};
   endfunction
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      print_verdict();
   end
   initial begin
      static logic [3:0] a [4] = '{LGS_OFS_SEL_LOW, LGS_OFS_SEL_HIGH,
         LGS_OFS_POL, LGS_OFS_SRC_SEL};
      static logic [31:0] e [4] = '{32'hffff, 32'hffff, 32'hf, 32'h7777};
      {cyc, stb, we, adr, dat_w, pick} = '0;
      rst_n = 1'b0;
      lvl = 4'h0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wb(1'b0, a[i], 32'h0);
         check("reset value", 32'h0, rd);
         wb(1'b1, a[i], 32'hffffffff);
         wb(1'b0, a[i], 32'h0);
         check("readback", e[i], rd);
         wb(1'b1, a[i], 32'h0);
      end
      $display("test registers done");
      for (int p = 0; p < 2; p++) begin
         lvl <= p ? 4'b1010 : 4'b0101;
         pol = p ? 4'h5 : 4'ha;
         wb(1'b1, LGS_OFS_POL, {28'h0, pol});
         for (int r = 0; r < 2; r++) begin
            for (int b = 0; b < 16; b++) begin
               wb(1'b1, r ? LGS_OFS_SEL_HIGH : LGS_OFS_SEL_LOW, 32'h1 << b);
               #1;
               ex = {4{tv(lvl)}} & (32'h1 << (16 * r + b));
               check("terms", ex, {t4, t3, t2, t1});
               repeat (2) @(posedge clk);
               #1;
               for (int g = 0; g < 4; g++) begin
                  check("gate out", {31'h0, |ex[8*g +: 8] ^ pol[g]},
                     {31'h0, gout[g]});
               end
            end
            wb(1'b1, r ? LGS_OFS_SEL_HIGH : LGS_OFS_SEL_LOW, 32'h0);
         end
      end
      $display("test gate enables done");
      lvl <= 4'b0101;
      wb(1'b1, LGS_OFS_SEL_LOW, 32'h00aa);
      for (int v = 0; v < 8; v++) begin
         pick <= 3'(v);
         wb(1'b1, LGS_OFS_SRC_SEL, {16'h0, {4{1'b0, 3'(v)}}});
         repeat (6) @(posedge clk);
         #1;
         check("source pick", {24'h0, tv(4'b0101) & 8'haa},
            {24'h0, t1});
      end
      $display("test source select done");
      print_verdict();
   end
endmodule // lgs_top_bench
